// ---- common/fmps_map.svh ----
// fmps_map.svh: register offsets, field positions, reset values and timing counts
// for the fan and motor protection supervisor; definitions only.
`ifndef FMPS_MAP_SVH
`define FMPS_MAP_SVH

`define FMPS_OFF_FAN_MODE    8'h00
`define FMPS_OFF_FAN_THR     8'h04
`define FMPS_OFF_RESTORE     8'h08
`define FMPS_OFF_OL_COEF     8'h0c
`define FMPS_OFF_LR_EN       8'h10
`define FMPS_OFF_LR_DELAY    8'h14
`define FMPS_OFF_OH_EN       8'h18
`define FMPS_OFF_SD_EN       8'h1c
`define FMPS_OFF_OH_LIMIT    8'h20
`define FMPS_OFF_LR_CURRENT  8'h24
`define FMPS_OFF_ZERO_SPEED  8'h28
`define FMPS_OFF_STATUS      8'h2c
`define FMPS_OFF_CLEAR       8'h30
`define FMPS_OFF_IRQ_EN      8'h34
`define FMPS_OFF_STATE       8'h38

`define FMPS_RST_FAN_MODE    16'h0002
`define FMPS_RST_FAN_THR     16'h002d
`define FMPS_RST_RESTORE     16'h0000
`define FMPS_RST_OL_COEF     16'h0064
`define FMPS_RST_LR_EN       16'h0001
`define FMPS_RST_LR_DELAY    16'h0032
`define FMPS_RST_OH_EN       16'h0000
`define FMPS_RST_SD_EN       16'h0001
`define FMPS_RST_OH_LIMIT    16'h0082
`define FMPS_RST_LR_CURRENT  16'h00c8
`define FMPS_RST_ZERO_SPEED  16'h000a

// status / clear / enable bit positions
`define FMPS_BIT_OVERLOAD    0
`define FMPS_BIT_LOCKED      1
`define FMPS_BIT_OVERHEAT    2
`define FMPS_BIT_SENSOR      3
`define FMPS_BIT_RESTORED    4
`define FMPS_NUM_EVENTS      5

// fan modes, temperatures in degrees C and rated current in percent
`define FMPS_MODE_TEMP       16'h0000
`define FMPS_MODE_POWER      16'h0001
`define FMPS_MODE_RUN        16'h0002
`define FMPS_FAN_HYST        16'h0005
`define FMPS_RUN_ON_TEMP     16'h002d
`define FMPS_RUN_OFF_TEMP    16'h0028
`define FMPS_RATED_PCT       16'h0064

// timing
`define FMPS_CLK_MHZ         200
`define FMPS_TICK_MS         10
`define FMPS_FAN_STOP_MS     500
`define FMPS_HOLD_MS         500
`define FMPS_RESTORE_MS      5000

`endif

// ---- common/fmps_pkg.sv ----
// fmps_pkg: types shared by the fan and motor protection supervisor.
// assumes fmps_map.svh for all numeric constants.
`default_nettype none
package fmps_pkg;
    typedef enum logic [1:0] {RS_IDLE, RS_HOLD, RS_SHOW} fmps_restore_e;
    typedef logic [15:0] fmps_word_t;
endpackage
`default_nettype wire

// ---- core/fmps_top.sv ----
// fmps_top: fan drive, factory restore sequencer and motor protection faults,
// with an APB register slave. assumes synchronous inputs on pclk (200 MHz),
// temperatures in whole degrees C and currents in percent of rated current.
// Function
// RULE1: fan mode 0 temperature, 1 always from power-on, 2 while running; default 2.
// RULE2: mode 0 turns fan on when radiator reaches threshold, default 45.
// RULE3: mode 0 turns fan off only below threshold minus five degrees.
// RULE4: mode 2 runs fan while servo on or radiator above 45 degrees.
// RULE5: mode 2 stops fan 500 ms after servo off and radiator below 40.
// RULE6: mode 1 runs fan continuously regardless of temperature or servo.
// RULE7: restore request 1 plus SET held 0.5 s shows 00000.
// RULE8: five seconds later all parameters reload their defaults.
// RULE9: heat model is generation minus release; rising heat flags overload.
// RULE10: overload trip time scales with coefficient percent, default 100.
// RULE11: locked rotor is near-zero speed with very high current.
// RULE12: locked-rotor protection has an enable, default on.
// RULE13: locked-rotor fault after condition persists delay times 10 ms.
// RULE14: motor overheat protection has an enable, default off.
// RULE15: sensor disconnection detection has an enable, default on.
// RULE16: locked-rotor timer restarts when the condition ceases early.
// RULE17: faults stay latched until an alarm reset clears them.
// RULE18: setting changes act at once, with no restart.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "fmps_map.svh"

module fmps_top #(
    parameter int unsigned TICK_CYCLES = `FMPS_TICK_MS * `FMPS_CLK_MHZ * 1000,
    parameter int unsigned OL_UNIT     = 100,
    parameter int unsigned HEAT_W      = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] radiator_temp,
    input  wire logic [15:0] motor_temp,
    input  wire logic        sensor_open,
    input  wire logic        servo_on,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] motor_current,
    input  wire logic        set_key,
    output logic             fan_on,
    output logic             restore_display,
    output logic             motor_overload_alarm,
    output logic             locked_rotor_alarm,
    output logic             overheat_alarm,
    output logic             sensor_alarm,
    output logic             heat_rising,
    output logic             irq
);

    localparam int unsigned FAN_STOP_TICKS =
        (`FMPS_FAN_STOP_MS + `FMPS_TICK_MS - 1) / `FMPS_TICK_MS;
    localparam int unsigned HOLD_TICKS =
        (`FMPS_HOLD_MS + `FMPS_TICK_MS - 1) / `FMPS_TICK_MS;
    localparam int unsigned SHOW_TICKS =
        (`FMPS_RESTORE_MS + `FMPS_TICK_MS - 1) / `FMPS_TICK_MS;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // settings
    fmps_pkg::fmps_word_t fan_mode_select;
    fmps_pkg::fmps_word_t fan_temperature_threshold;
    fmps_pkg::fmps_word_t factory_restore_request;
    fmps_pkg::fmps_word_t overload_coefficient;
    fmps_pkg::fmps_word_t locked_rotor_enable;
    fmps_pkg::fmps_word_t locked_rotor_delay;
    fmps_pkg::fmps_word_t overheat_enable;
    fmps_pkg::fmps_word_t sensor_disconnect_enable;
    fmps_pkg::fmps_word_t overheat_limit;
    fmps_pkg::fmps_word_t locked_rotor_current;
    fmps_pkg::fmps_word_t zero_speed_limit;
    logic [`FMPS_NUM_EVENTS-1:0] event_status;
    logic [`FMPS_NUM_EVENTS-1:0] irq_enable;

    // apb decode
    wire        access     = psel & penable;
    wire        wr         = access & pwrite;
    wire        w_mode     = wr & hit(paddr, `FMPS_OFF_FAN_MODE);
    wire        w_thr      = wr & hit(paddr, `FMPS_OFF_FAN_THR);
    wire        w_restore  = wr & hit(paddr, `FMPS_OFF_RESTORE);
    wire        w_coef     = wr & hit(paddr, `FMPS_OFF_OL_COEF);
    wire        w_lr_en    = wr & hit(paddr, `FMPS_OFF_LR_EN);
    wire        w_lr_dly   = wr & hit(paddr, `FMPS_OFF_LR_DELAY);
    wire        w_oh_en    = wr & hit(paddr, `FMPS_OFF_OH_EN);
    wire        w_sd_en    = wr & hit(paddr, `FMPS_OFF_SD_EN);
    wire        w_oh_lim   = wr & hit(paddr, `FMPS_OFF_OH_LIMIT);
    wire        w_lr_cur   = wr & hit(paddr, `FMPS_OFF_LR_CURRENT);
    wire        w_zero     = wr & hit(paddr, `FMPS_OFF_ZERO_SPEED);
    wire        w_clear    = wr & hit(paddr, `FMPS_OFF_CLEAR);
    wire        w_irq_en   = wr & hit(paddr, `FMPS_OFF_IRQ_EN);
    wire        mapped     = (paddr <= `FMPS_OFF_STATE) && (paddr[1:0] == 2'h0);
    wire [15:0] wdata      = pwdata[15:0];
    wire [`FMPS_NUM_EVENTS-1:0] clear_bits =
        w_clear ? pwdata[`FMPS_NUM_EVENTS-1:0] : '0;

    // 10 ms time base shared by every timer
    logic [31:0] tick_cnt;
    wire         tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    // factory restore sequencer
    fmps_pkg::fmps_restore_e rs_state;
    fmps_pkg::fmps_restore_e next_rs_state;
    logic [15:0] rs_cnt;
    wire rs_armed   = (factory_restore_request == 16'h0001);
    wire hold_done  = tick && (rs_cnt == 16'(HOLD_TICKS - 1));
    wire show_done  = tick && (rs_cnt == 16'(SHOW_TICKS - 1));
    wire reload     = (rs_state == fmps_pkg::RS_SHOW) && show_done; // RULE8

    always_comb begin
        next_rs_state = rs_state;
        case (rs_state)
            fmps_pkg::RS_IDLE: begin
                if (rs_armed && set_key) next_rs_state = fmps_pkg::RS_HOLD;
            end
            fmps_pkg::RS_HOLD: begin
                // releasing SET or withdrawing the request aborts
                if (!set_key || !rs_armed) next_rs_state = fmps_pkg::RS_IDLE;
                else if (hold_done) next_rs_state = fmps_pkg::RS_SHOW; // RULE7
            end
            fmps_pkg::RS_SHOW: begin
                if (show_done) next_rs_state = fmps_pkg::RS_IDLE;
            end
            default: next_rs_state = fmps_pkg::RS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs_state <= fmps_pkg::RS_IDLE;
            rs_cnt   <= 16'h0;
        end else begin
            rs_state <= next_rs_state;
            if (next_rs_state != rs_state) rs_cnt <= 16'h0;
            else if (tick) rs_cnt <= rs_cnt + 16'h1;
        end
    end

    assign restore_display = (rs_state == fmps_pkg::RS_SHOW); // RULE7

    // settings take effect on the write itself; reload beats a racing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_mode_select           <= `FMPS_RST_FAN_MODE;
            fan_temperature_threshold <= `FMPS_RST_FAN_THR;
            factory_restore_request   <= `FMPS_RST_RESTORE;
            overload_coefficient      <= `FMPS_RST_OL_COEF;
            locked_rotor_enable       <= `FMPS_RST_LR_EN;
            locked_rotor_delay        <= `FMPS_RST_LR_DELAY;
            overheat_enable           <= `FMPS_RST_OH_EN;
            sensor_disconnect_enable  <= `FMPS_RST_SD_EN;
            overheat_limit            <= `FMPS_RST_OH_LIMIT;
            locked_rotor_current      <= `FMPS_RST_LR_CURRENT;
            zero_speed_limit          <= `FMPS_RST_ZERO_SPEED;
        end else if (reload) begin // RULE8
            fan_mode_select           <= `FMPS_RST_FAN_MODE;
            fan_temperature_threshold <= `FMPS_RST_FAN_THR;
            factory_restore_request   <= `FMPS_RST_RESTORE;
            overload_coefficient      <= `FMPS_RST_OL_COEF;
            locked_rotor_enable       <= `FMPS_RST_LR_EN;
            locked_rotor_delay        <= `FMPS_RST_LR_DELAY;
            overheat_enable           <= `FMPS_RST_OH_EN;
            sensor_disconnect_enable  <= `FMPS_RST_SD_EN;
            overheat_limit            <= `FMPS_RST_OH_LIMIT;
            locked_rotor_current      <= `FMPS_RST_LR_CURRENT;
            zero_speed_limit          <= `FMPS_RST_ZERO_SPEED;
        end else begin // RULE18
            if (w_mode)    fan_mode_select           <= wdata;
            if (w_thr)     fan_temperature_threshold <= wdata;
            if (w_restore) factory_restore_request   <= wdata;
            if (w_coef)    overload_coefficient      <= wdata;
            if (w_lr_en)   locked_rotor_enable       <= wdata;
            if (w_lr_dly)  locked_rotor_delay        <= wdata;
            if (w_oh_en)   overheat_enable           <= wdata;
            if (w_sd_en)   sensor_disconnect_enable  <= wdata;
            if (w_oh_lim)  overheat_limit            <= wdata;
            if (w_lr_cur)  locked_rotor_current      <= wdata;
            if (w_zero)    zero_speed_limit          <= wdata;
        end
    end

    // fan control
    wire [15:0] thr_low   = fan_temperature_threshold - `FMPS_FAN_HYST;
    wire mode_temp        = (fan_mode_select == `FMPS_MODE_TEMP);
    wire mode_power       = (fan_mode_select == `FMPS_MODE_POWER);
    wire mode_run         = (fan_mode_select == `FMPS_MODE_RUN);
    wire temp_on          = radiator_temp >= fan_temperature_threshold; // RULE2
    wire temp_off         = radiator_temp < thr_low; // RULE3
    wire run_on           = servo_on || (radiator_temp > `FMPS_RUN_ON_TEMP); // RULE4
    wire run_stop         = !servo_on && (radiator_temp < `FMPS_RUN_OFF_TEMP);
    logic [15:0] stop_cnt;
    wire stop_done        = run_stop && tick && (stop_cnt == 16'(FAN_STOP_TICKS - 1));
    logic next_fan_on;

    always_comb begin
        next_fan_on = fan_on;
        if (mode_power) next_fan_on = 1'b1; // RULE6
        else if (mode_temp) begin
            if (temp_on) next_fan_on = 1'b1; // RULE2
            else if (temp_off) next_fan_on = 1'b0; // RULE3
        end else if (mode_run) begin
            if (run_on) next_fan_on = 1'b1; // RULE4
            else if (stop_done) next_fan_on = 1'b0; // RULE5
        end else begin
            // undefined mode codes keep the fan running: the safe side
            next_fan_on = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_on   <= 1'b0;
            stop_cnt <= 16'h0;
        end else begin
            fan_on <= next_fan_on; // RULE1
            if (!mode_run || !run_stop || !fan_on) stop_cnt <= 16'h0; // RULE5
            else if (tick) stop_cnt <= stop_cnt + 16'h1;
        end
    end

    // thermal model: generation is current, release is rated current
    logic [HEAT_W-1:0] heat;
    wire [15:0] excess  = motor_current - `FMPS_RATED_PCT;
    wire [15:0] deficit = `FMPS_RATED_PCT - motor_current;
    wire gen_gt_rel     = motor_current > `FMPS_RATED_PCT;
    wire [HEAT_W-1:0] ol_limit = HEAT_W'(overload_coefficient) * HEAT_W'(OL_UNIT); // RULE10
    wire ol_trip        = gen_gt_rel && (heat > ol_limit); // RULE9
    assign heat_rising  = gen_gt_rel; // RULE9

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heat <= '0;
        end else if (tick) begin
            if (gen_gt_rel) heat <= heat + HEAT_W'(excess); // RULE9
            else if (heat > HEAT_W'(deficit)) heat <= heat - HEAT_W'(deficit);
            else heat <= '0;
        end
    end

    // locked rotor persistence
    wire lr_en   = locked_rotor_enable[0]; // RULE12
    wire lr_cond = lr_en && (motor_speed <= zero_speed_limit)
                   && (motor_current >= locked_rotor_current); // RULE11
    logic [15:0] lr_cnt;
    wire lr_trip = lr_cond && (lr_cnt >= locked_rotor_delay); // RULE13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lr_cnt <= 16'h0;
        end else if (!lr_cond) begin
            lr_cnt <= 16'h0; // RULE16
        end else if (tick && !lr_trip) begin
            lr_cnt <= lr_cnt + 16'h1;
        end
    end

    wire oh_trip = overheat_enable[0] && (motor_temp > overheat_limit); // RULE14
    wire sd_trip = sensor_disconnect_enable[0] && sensor_open; // RULE15

    // sticky events: set beats the clear of the same cycle
    wire [`FMPS_NUM_EVENTS-1:0] ev_set = {reload, sd_trip, oh_trip, lr_trip, ol_trip};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status <= '0;
            irq_enable   <= '0;
        end else begin
            event_status <= (event_status & ~clear_bits) | ev_set; // RULE17
            if (w_irq_en) irq_enable <= pwdata[`FMPS_NUM_EVENTS-1:0];
        end
    end

    assign motor_overload_alarm = event_status[`FMPS_BIT_OVERLOAD];
    assign locked_rotor_alarm   = event_status[`FMPS_BIT_LOCKED];
    assign overheat_alarm       = event_status[`FMPS_BIT_OVERHEAT];
    assign sensor_alarm         = event_status[`FMPS_BIT_SENSOR];
    assign irq                  = |(event_status & irq_enable);

    // read mux
    wire [31:0] state_word = {27'h0, heat_rising, restore_display, 1'b0, 1'b0, fan_on};
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        case (paddr)
            `FMPS_OFF_FAN_MODE:   rd_mux = {16'h0, fan_mode_select};
            `FMPS_OFF_FAN_THR:    rd_mux = {16'h0, fan_temperature_threshold};
            `FMPS_OFF_RESTORE:    rd_mux = {16'h0, factory_restore_request};
            `FMPS_OFF_OL_COEF:    rd_mux = {16'h0, overload_coefficient};
            `FMPS_OFF_LR_EN:      rd_mux = {16'h0, locked_rotor_enable};
            `FMPS_OFF_LR_DELAY:   rd_mux = {16'h0, locked_rotor_delay};
            `FMPS_OFF_OH_EN:      rd_mux = {16'h0, overheat_enable};
            `FMPS_OFF_SD_EN:      rd_mux = {16'h0, sensor_disconnect_enable};
            `FMPS_OFF_OH_LIMIT:   rd_mux = {16'h0, overheat_limit};
            `FMPS_OFF_LR_CURRENT: rd_mux = {16'h0, locked_rotor_current};
            `FMPS_OFF_ZERO_SPEED: rd_mux = {16'h0, zero_speed_limit};
            `FMPS_OFF_STATUS:     rd_mux = {27'h0, event_status};
            `FMPS_OFF_IRQ_EN:     rd_mux = {27'h0, irq_enable};
            `FMPS_OFF_STATE:      rd_mux = state_word;
            default:              rd_mux = 32'h0;
        endcase
    end

    // zero-wait slave: data comes from a register loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hold_done;
        (rs_state == fmps_pkg::RS_HOLD) && set_key && rs_armed && hold_done;
    endsequence

    sequence s_show_done;
        (rs_state == fmps_pkg::RS_SHOW) && show_done;
    endsequence

    a_fan_power_mode: assert property (mode_power |=> fan_on) // RULE6
        else $error("fan off in power-on mode");
    a_fan_temp_on: assert property (mode_temp && temp_on |=> fan_on) // RULE2
        else $error("fan not on at threshold");
    a_fan_hyst_off: assert property (mode_temp && temp_off && !temp_on |=> !fan_on) // RULE3
        else $error("fan not off below hysteresis");
    a_fan_hyst_hold: assert property (mode_temp && !temp_on && !temp_off
        ##1 mode_temp && !temp_on && !temp_off |-> fan_on == $past(fan_on)) // RULE3
        else $error("fan changed inside band");
    a_fan_run_on: assert property (mode_run && run_on |=> fan_on) // RULE4
        else $error("fan not on while running");
    a_fan_stop_delay: assert property ($fell(fan_on) && $past(mode_run)
        |-> $past(stop_cnt) == 16'(FAN_STOP_TICKS - 1) && $past(tick)) // RULE5
        else $error("fan stopped before delay");
    a_restore_show: assert property (s_hold_done |=> restore_display) // RULE7
        else $error("restore display missing");
    a_restore_load: assert property (s_show_done |=> fan_mode_select == `FMPS_RST_FAN_MODE
        && factory_restore_request == `FMPS_RST_RESTORE && !restore_display) // RULE8
        else $error("defaults not reloaded");
    a_overload_flag: assert property (ol_trip |=> motor_overload_alarm) // RULE9
        else $error("overload not flagged");
    a_lock_restart: assert property (!lr_cond |=> lr_cnt == 16'h0) // RULE16
        else $error("lock timer not restarted");
    a_lock_disabled: assert property (!lr_en |=> !$rose(locked_rotor_alarm)) // RULE12
        else $error("lock fault while disabled");
    a_lock_trip: assert property ($rose(locked_rotor_alarm)
        |-> $past(lr_cnt) >= $past(locked_rotor_delay) && $past(lr_cond)) // RULE13
        else $error("lock fault before delay");
    a_overheat_gate: assert property (!overheat_enable[0] && !$past(overheat_enable[0])
        |-> !$rose(overheat_alarm)) // RULE14
        else $error("overheat fault while disabled");
    a_sensor_flag: assert property (sd_trip |=> sensor_alarm) // RULE15
        else $error("sensor fault not raised");
    a_fault_latched: assert property (locked_rotor_alarm && !clear_bits[`FMPS_BIT_LOCKED]
        |=> locked_rotor_alarm) // RULE17
        else $error("fault dropped without clear");
    a_setting_now: assert property (w_thr && !reload |=> fan_temperature_threshold
        == $past(wdata)) // RULE18
        else $error("setting write not immediate");

endmodule // fmps_top

`default_nettype wire

// ---- tb/fmps_keypad.sv ----
// fmps_keypad: operator model that holds the SET key for a commanded span.
// assumes the pclk domain; press is a one-cycle request from the bench.
`timescale 1ns/10ps
`default_nettype none
module fmps_keypad (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        press,
    input  wire logic [15:0] hold_cycles,
    output logic             set_key
);
    logic [15:0] left;
    assign set_key = (left != 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            left <= 16'h0000;
        else if (press)
            left <= hold_cycles;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
endmodule // fmps_keypad
`default_nettype wire

// ---- tb/tb_top.sv ----
// tb_top: register, fan, fault and restore tests for fmps_top.
// assumes fmps_map.svh on the include path; one tick shortened to 4 cycles.
`timescale 1ns/10ps
`default_nettype none
`include "fmps_map.svh"
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err_seen, sensor_open = 1'b0, servo_on = 1'b0;
    logic [15:0] radiator_temp = 16'h0019, motor_temp = 16'h0019, hold_cycles = 16'h0000;
    logic [15:0] motor_speed = 16'h0000, motor_current = 16'h0000;
    logic        set_key, press = 1'b0, fan_on, restore_display, heat_rising, irq;
    logic        motor_overload_alarm, locked_rotor_alarm, overheat_alarm, sensor_alarm;
    logic [15:0] rv [8] = '{16'h2, 16'h2d, 16'h0, 16'h64, 16'h1, 16'h32, 16'h0, 16'h1};
    int          err_total = 0;
    int          samples_checked = 0;

    always #2.5 pclk = ~pclk;

    fmps_top #(.TICK_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .radiator_temp, .motor_temp, .sensor_open,
        .servo_on, .motor_speed, .motor_current, .set_key, .fan_on, .restore_display,
        .motor_overload_alarm, .locked_rotor_alarm, .overheat_alarm, .sensor_alarm,
        .heat_rising, .irq);
    fmps_keypad kp (.pclk, .presetn, .press, .hold_cycles, .set_key);

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one idle edge first, so back-to-back calls never reassign psel in one step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        end_of_test();
    end

    initial begin
        cyc(8);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rd, {16'h0, rv[i]});
        end
        xfer(1'b0, 8'h3c, 32'h0);
        chk("unmapped error", {31'h0, err_seen}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        servo_on <= 1'b1;
        cyc(3);
        chk("fan servo on", fan_on, 32'h1);
        servo_on <= 1'b0;
        cyc(180);
        chk("fan stop delay", fan_on, 32'h1);
        cyc(40);
        chk("fan stopped", fan_on, 32'h0);
        radiator_temp <= 16'h002e;
        cyc(3);
        chk("fan hot", fan_on, 32'h1);
        xfer(1'b1, `FMPS_OFF_FAN_MODE, 32'h0);
        radiator_temp <= 16'h0028;
        cyc(3);
        chk("fan in band", fan_on, 32'h1);
        radiator_temp <= 16'h0027;
        cyc(3);
        chk("fan below band", fan_on, 32'h0);
        radiator_temp <= 16'h002d;
        cyc(3);
        chk("fan at threshold", fan_on, 32'h1);
        xfer(1'b1, `FMPS_OFF_FAN_THR, 32'h3c);
        cyc(2);
        chk("fan new threshold", fan_on, 32'h0);
        xfer(1'b1, `FMPS_OFF_FAN_MODE, 32'h1);
        cyc(2);
        chk("fan always", fan_on, 32'h1);
        $display("test fan done");
        xfer(1'b1, `FMPS_OFF_LR_DELAY, 32'ha);
        motor_current <= 16'h00c8;
        cyc(20);
        motor_speed <= 16'h0014;
        cyc(2);
        motor_speed <= 16'h0000;
        cyc(30);
        chk("locked early", locked_rotor_alarm, 32'h0);
        cyc(30);
        chk("locked trip", locked_rotor_alarm, 32'h1);
        motor_current <= 16'h0000;
        cyc(80);
        chk("locked latched", locked_rotor_alarm, 32'h1);
        xfer(1'b1, `FMPS_OFF_CLEAR, 32'h2);
        xfer(1'b1, `FMPS_OFF_LR_EN, 32'h0);
        chk("locked cleared", locked_rotor_alarm, 32'h0);
        motor_current <= 16'h00c8;
        cyc(60);
        chk("locked disabled", locked_rotor_alarm, 32'h0);
        motor_current <= 16'h0000;
        cyc(160);
        // drained heat, so a small coefficient shows the scaling
        xfer(1'b1, `FMPS_OFF_OL_COEF, 32'h1);
        motor_current <= 16'h0096;
        cyc(2);
        chk("heat rising", heat_rising, 32'h1);
        chk("overload early", motor_overload_alarm, 32'h0);
        cyc(16);
        chk("overload trip", motor_overload_alarm, 32'h1);
        motor_current <= 16'h0000;
        motor_temp <= 16'h00c8;
        cyc(3);
        chk("overheat off", overheat_alarm, 32'h0);
        xfer(1'b1, `FMPS_OFF_OH_EN, 32'h1);
        cyc(2);
        chk("overheat on", overheat_alarm, 32'h1);
        xfer(1'b1, `FMPS_OFF_IRQ_EN, 32'h8);
        sensor_open <= 1'b1;
        cyc(3);
        chk("sensor irq", {sensor_alarm, irq}, 32'h3);
        sensor_open <= 1'b0;
        xfer(1'b1, `FMPS_OFF_IRQ_EN, 32'h0);
        cyc(1);
        chk("irq masked", {sensor_alarm, irq}, 32'h2);
        xfer(1'b1, `FMPS_OFF_CLEAR, 32'h8);
        cyc(1);
        chk("sensor cleared", sensor_alarm, 32'h0);
        $display("test faults done");
        xfer(1'b1, `FMPS_OFF_RESTORE, 32'h1);
        hold_cycles <= 16'h0064;
        press <= 1'b1;
        cyc(1);
        press <= 1'b0;
        cyc(240);
        chk("restore short hold", restore_display, 32'h0);
        hold_cycles <= 16'h0118;
        press <= 1'b1;
        cyc(1);
        press <= 1'b0;
        cyc(230);
        chk("restore shown", restore_display, 32'h1);
        cyc(1900);
        chk("restore waiting", restore_display, 32'h1);
        cyc(200);
        xfer(1'b0, `FMPS_OFF_FAN_THR, 32'h0);
        chk("restored threshold", rd, 32'h2d);
        xfer(1'b0, `FMPS_OFF_FAN_MODE, 32'h0);
        chk("restored mode", rd, 32'h2);
        xfer(1'b0, `FMPS_OFF_STATUS, 32'h0);
        chk("restore event", rd, 32'h15);
        xfer(1'b0, `FMPS_OFF_STATE, 32'h0);
        chk("state word", rd, 32'h1);
        $display("test restore done");
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
